// ==== bench/pdx_checker_properties.sv ====
// checker: bus write to control output relations
`timescale 1ns/1ps
module pdx_checker (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic [3:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic [11:0] o_ref_divide_count,
  input wire logic        o_main_loop_shutdown,
  input wire logic [10:0] o_fb_m_count,
  input wire logic [3:0]  o_post_stage_a,
  input wire logic [3:0]  o_post_stage_b,
  input wire logic [3:0]  o_post_stage_c,
  input wire logic [7:0]  o_post_ratio_total,
  input wire logic [1:0]  o_xtal_pump_current,
  input wire logic [2:0]  o_xtal_divider_select,
  input wire logic [11:0] o_xtal_divide_ratio,
  input wire logic        o_xtal_osc_powerdown,
  input wire logic        o_xtal_fine_tune_enable,
  input wire logic        o_xtal_tune_polarity,
  input wire logic        o_xtal_loop_powerdown,
  input wire logic [3:0]  o_crystal_load_trim
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // one-cycle write to a byte
  sequence s_wr(logic [3:0] a);
    i_wr && i_addr == a;
  endsequence
  a_ref_commit: assert property (
    s_wr(4'h1) |=> o_ref_divide_count[11:8] == $past(i_wdata[3:0])
      && o_main_loop_shutdown == $past(i_wdata[5]))
    else $error("ref upper byte not taken");
  a_ref_staged: assert property (
    s_wr(4'h0) |=> $stable(o_ref_divide_count))
    else $error("ref count moved on low byte");
  a_fb_commit: assert property (
    s_wr(4'h4) |=> o_fb_m_count[10:5] == $past(i_wdata[5:0]))
    else $error("feedback count not taken");
  a_post_total: assert property (
    o_post_ratio_total == {4'h0, o_post_stage_a} * o_post_stage_b * o_post_stage_c)
    else $error("post total is not the product");
  a_xtal_byte: assert property (
    s_wr(4'h6) |=> o_xtal_pump_current == $past(i_wdata[5:4])
      && o_xtal_tune_polarity == $past(i_wdata[6]) && o_xtal_loop_powerdown == $past(i_wdata[7]))
    else $error("crystal loop byte not taken");
  a_trim_byte: assert property (
    s_wr(4'h7) |=> o_crystal_load_trim == $past(i_wdata[3:0])
      && o_xtal_fine_tune_enable == $past(i_wdata[5]))
    else $error("trim byte not taken");
  a_osc_off: assert property (
    o_xtal_osc_powerdown == (o_xtal_divider_select == 3'h7))
    else $error("oscillator power-down mismatch");
  a_xdiv_ratio: assert property (
    o_xtal_divider_select == 3'h1 |-> o_xtal_divide_ratio == 12'hc00)
    else $error("crystal divide ratio wrong");
endmodule

// ==== bench/pdx_host_model.sv ====
// host model: drives the byte-wide control bus
`timescale 1ns/1ps
module pdx_host_model (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_rdata,
  output logic      [3:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  // bus idle at time zero
  initial begin
    o_addr = 4'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // one-cycle write, reserved bits of byte 2 kept clear
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_wdata <= (a == 4'h2) ? (d & 8'h3f) : d;
    o_wr <= 1'b1;
    @(posedge i_clock);
    o_wr <= 1'b0;
    #1;
  endtask
  // one-cycle read, data taken in the cycle after
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clock);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule

// ==== bench/testbench.sv ====
// testbench: bus-driven checks of the clock config block
`timescale 1ns/1ps
module testbench;
  logic        i_clock, i_rst, i_wr, i_rd, i_ref_tick, i_vco_tick, o_pd_ref_tick, o_post_tick;
  logic        o_main_loop_shutdown, o_xtal_osc_powerdown, o_xtal_fine_tune_enable;
  logic        o_xtal_tune_polarity, o_xtal_loop_powerdown;
  logic [3:0]  i_addr, o_post_stage_a, o_post_stage_b, o_post_stage_c, o_crystal_load_trim;
  logic [7:0]  i_wdata, o_rdata, o_post_ratio_total, o_xtal_pump_tenth_ua, rv;
  logic [2:0]  o_fb_a_count, o_xtal_divider_select;
  logic [1:0]  o_xtal_pump_current;
  logic [10:0] o_fb_m_count;
  logic [11:0] o_ref_divide_count, o_xtal_divide_ratio, o_load_cap_centi_pf;
  int          fails = 0;
  int          comparisons = 0;
  int          k;
  logic [11:0] n;
  logic [11:0] xr[8] = '{12'd1, 12'd3072, 12'd3156, 12'd2430, 12'd2500, 12'd4000, 12'd3375, 12'd0};
  logic [11:0] cap[16] = '{12'd1000, 12'd1084, 12'd1169, 12'd1253, 12'd1338, 12'd1422, 12'd1506,
    12'd1591, 12'd1675, 12'd1759, 12'd1843, 12'd1928, 12'd2013, 12'd2097, 12'd2181, 12'd2266};
  logic [7:0]  pu[4] = '{8'd15, 8'd50, 8'd80, 8'd240};
  logic [3:0]  pa[4] = '{4'd1, 4'd2, 4'd4, 4'd8};
  logic [3:0]  pb[4] = '{4'd1, 4'd3, 4'd5, 4'd4};
  pdx_clock_config DUT (.*);
  pdx_host_model host (.i_clock(i_clock), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));
  initial i_clock = 1'b0;
  always #5 i_clock = ~i_clock;
  // compare and count
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // count output pulses over a span of cycles
  task automatic pulses(input int c, input bit sel, output logic [11:0] p);
    p = 12'h000;
    repeat (c) begin
      @(posedge i_clock);
      #1;
      p += sel ? o_post_tick : o_pd_ref_tick;
    end
  endtask
  task automatic results;
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    i_rst = 1'b1;
    i_ref_tick = 1'b0;
    i_vco_tick = 1'b0;
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    host.wr(4'h0, 8'h03);
    chk(o_ref_divide_count, 12'd0);
    host.wr(4'h1, 8'h20);
    chk(o_ref_divide_count, 12'd3);
    host.rd(4'h8, rv);
    chk(rv[4:0], 5'h10);
    host.wr(4'h3, 8'hd5);
    chk(o_fb_a_count, 3'h0);
    host.rd(4'h8, rv);
    chk(rv[1:0], 2'h2);
    host.wr(4'h4, 8'h2a);
    chk({o_fb_m_count, o_fb_a_count}, 14'h2ad5);
    host.wr(4'h2, 8'h05);
    host.rd(4'h2, rv);
    chk(rv, 8'h05);
    i_ref_tick <= 1'b1;
    i_vco_tick <= 1'b1;
    pulses(20, 1'b0, n);
    pulses(30, 1'b0, n);
    chk(n, 12'd10);
    pulses(60, 1'b1, n);
    chk(n, 12'd10);
    i_ref_tick <= 1'b0;
    i_vco_tick <= 1'b0;
    for (k = 0; k < 64; k++) begin
      host.wr(4'h2, 8'(k));
      chk(o_post_stage_a, pa[k%4]);
      chk(o_post_stage_b, pb[(k/4)%4]);
      chk(o_post_stage_c, pb[k/16]);
      chk(o_post_ratio_total, pa[k%4] * pb[(k/4)%4] * pb[k/16]);
    end
    for (k = 0; k < 8; k++) begin
      host.wr(4'h6, {k[1], k[0], k[1:0], k[2:0], 1'b0});
      chk(o_xtal_divide_ratio, xr[k]);
      chk({o_xtal_pump_current, o_xtal_pump_tenth_ua}, {k[1:0], pu[k%4]});
      chk({o_xtal_tune_polarity, o_xtal_loop_powerdown}, {k[0], k[1]});
      chk({o_xtal_divider_select, o_xtal_osc_powerdown}, {k[2:0], k == 7});
      host.rd(4'h8, rv);
      chk(rv[3:2], {k[1], k == 7});
    end
    for (k = 0; k < 16; k++) begin
      host.wr(4'h7, {2'b00, k[0], 1'b0, k[3:0]});
      chk({o_crystal_load_trim, o_load_cap_centi_pf}, {k[3:0], cap[k]});
      chk(o_xtal_fine_tune_enable, k[0]);
    end
    host.wr(4'h1, 8'h00);
    chk(o_main_loop_shutdown, 1'b0);
    results;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    results;
  end
endmodule
bind pdx_clock_config pdx_checker u_chk (.*);

// ==== hw/pdx_clock_config.sv ====
// clock generator divider and crystal loop configuration block
//
// How it works
// - reference divide count is control bits 11..0, divides reference ticks.
// - feedback count bits 37..24; low three bits A value, upper eleven M value.
// - bits 53..52 pick crystal pump current 1.5, 5, 8, 24 microamps.
// - bits 51..49 pick crystal loop divide ratio from fixed table.
// - all-ones divider select powers down the crystal oscillator.
// - bit 61 enables crystal loop fine tuning.
// - bit 54 sets crystal loop tune polarity.
// - bit 55 powers down the crystal loop.
// - bits 59..56 pick one of sixteen load capacitance steps.
// - bit 13 shuts down the main loop.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module pdx_clock_config (
  input  wire logic                      i_clock,
  input  wire logic                      i_rst,
  input  wire logic [pdx_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [pdx_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [pdx_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                      i_ref_tick,
  input  wire logic                      i_vco_tick,
  output logic                           o_pd_ref_tick,
  output logic                           o_post_tick,
  output logic      [11:0]               o_ref_divide_count,
  output logic                           o_main_loop_shutdown,
  output logic      [2:0]                o_fb_a_count,
  output logic      [10:0]               o_fb_m_count,
  output logic      [3:0]                o_post_stage_a,
  output logic      [3:0]                o_post_stage_b,
  output logic      [3:0]                o_post_stage_c,
  output logic      [7:0]                o_post_ratio_total,
  output logic      [1:0]                o_xtal_pump_current,
  output logic      [7:0]                o_xtal_pump_tenth_ua,
  output logic      [2:0]                o_xtal_divider_select,
  output logic      [11:0]               o_xtal_divide_ratio,
  output logic                           o_xtal_osc_powerdown,
  output logic                           o_xtal_fine_tune_enable,
  output logic                           o_xtal_tune_polarity,
  output logic                           o_xtal_loop_powerdown,
  output logic      [3:0]                o_crystal_load_trim,
  output logic      [11:0]               o_load_cap_centi_pf
);

  typedef struct packed {
    logic [63:0] stage;      // bytes as written by the host
    logic [63:0] active;     // settings in force
    logic [7:0]  rdata;
    logic        pend_ref;
    logic        pend_fb;
    logic [3:0]  post_a;
    logic [3:0]  post_b;
    logic [3:0]  post_c;
    logic [7:0]  post_total;
    logic [7:0]  pump_ua;
    logic [11:0] xdiv;
    logic        osc_pd;
    logic [11:0] cap;
  } pdx_state_type;

  pdx_state_type st_r;
  pdx_state_type st_nxt;

  // bits that become active when control byte k is written
  function automatic logic [63:0] commit_mask(input logic [2:0] k);
    logic [63:0] m;
    m = pdx_pkg::BYTE0_MASK << (8 * k);
    // low bytes of split fields only stage, nothing goes live yet
    if ((k == pdx_pkg::REF_LO_BYTE) || (k == pdx_pkg::FB_LO_BYTE)) begin
      m = 64'h0;
    end
    if (k == pdx_pkg::REF_HI_BYTE) begin
      m = m | pdx_pkg::REF_LO_MASK;
    end
    if (k == pdx_pkg::FB_HI_BYTE) begin
      m = m | pdx_pkg::FB_LO_MASK;
    end
    return m;
  endfunction

  logic [2:0]  wr_byte;
  logic [63:0] wr_stage;
  logic [63:0] act;
  logic [7:0]  status;

  assign wr_byte = i_addr[2:0];

  // status view of the block's own state
  always_comb begin
    status                       = 8'h00;
    status[pdx_pkg::ST_PEND_REF] = st_r.pend_ref;
    status[pdx_pkg::ST_PEND_FB]  = st_r.pend_fb;
    status[pdx_pkg::ST_OSC_PD]   = st_r.osc_pd;
    status[pdx_pkg::ST_XPD]      = st_r.active[pdx_pkg::XPD_BIT];
    status[pdx_pkg::ST_SHUT]     = st_r.active[pdx_pkg::SHUT_BIT];
  end

  // bus writes, field commit, read data and decoded settings
  always_comb begin
    st_nxt   = st_r;
    wr_stage = st_r.stage;
    act      = st_r.active;
    if (i_wr && (i_addr <= pdx_pkg::CTRL_LAST_ADR)) begin
      wr_stage[8*wr_byte +: 8] = i_wdata;
      wr_stage                 = wr_stage & ~pdx_pkg::RSV_MASK;
      act = (act & ~commit_mask(wr_byte)) | (wr_stage & commit_mask(wr_byte));
      if (wr_byte == pdx_pkg::REF_LO_BYTE) begin
        st_nxt.pend_ref = 1'b1;
      end else if (wr_byte == pdx_pkg::REF_HI_BYTE) begin
        st_nxt.pend_ref = 1'b0;
      end
      if (wr_byte == pdx_pkg::FB_LO_BYTE) begin
        st_nxt.pend_fb = 1'b1;
      end else if (wr_byte == pdx_pkg::FB_HI_BYTE) begin
        st_nxt.pend_fb = 1'b0;
      end
    end
    st_nxt.stage  = wr_stage;
    st_nxt.active = act;

    // read answer stands one cycle after the strobe, zero otherwise
    st_nxt.rdata = 8'h00;
    if (i_rd) begin
      if (i_addr <= pdx_pkg::CTRL_LAST_ADR) begin
        st_nxt.rdata = st_r.stage[8*wr_byte +: 8];
      end else if (i_addr == pdx_pkg::STATUS_ADR) begin
        st_nxt.rdata = status;
      end
    end

    // decoded views of the active word
    st_nxt.post_a = pdx_pkg::POST_A_TAB[act[pdx_pkg::POSTA_LSB +: 2]];
    st_nxt.post_b = pdx_pkg::POST_BC_TAB[act[pdx_pkg::POSTB_LSB +: 2]];
    st_nxt.post_c = pdx_pkg::POST_BC_TAB[act[pdx_pkg::POSTC_LSB +: 2]];
    st_nxt.post_total = 8'({4'h0, st_nxt.post_a} * st_nxt.post_b * st_nxt.post_c);
    st_nxt.pump_ua = pdx_pkg::PUMP_TAB[act[pdx_pkg::PUMP_LSB +: 2]];
    st_nxt.xdiv    = pdx_pkg::XDIV_TAB[act[pdx_pkg::XDIV_LSB +: 3]];
    st_nxt.osc_pd  = (act[pdx_pkg::XDIV_LSB +: 3] == pdx_pkg::XDIV_OFF_CODE);
    st_nxt.cap     = pdx_pkg::CAP_TAB[act[pdx_pkg::TRIM_LSB +: 4]];
  end

  // state register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_r.stage      <= pdx_pkg::CTRL_RESET;
      st_r.active     <= pdx_pkg::CTRL_RESET;
      st_r.rdata      <= pdx_pkg::RDATA_RESET;
      st_r.pend_ref   <= 1'b0;
      st_r.pend_fb    <= 1'b0;
      st_r.post_a     <= pdx_pkg::POST_A_TAB[0];
      st_r.post_b     <= pdx_pkg::POST_BC_TAB[0];
      st_r.post_c     <= pdx_pkg::POST_BC_TAB[0];
      st_r.post_total <= 8'h01;
      st_r.pump_ua    <= pdx_pkg::PUMP_TAB[0];
      st_r.xdiv       <= pdx_pkg::XDIV_TAB[0];
      st_r.osc_pd     <= 1'b0;
      st_r.cap        <= pdx_pkg::CAP_TAB[0];
    end else begin
      st_r <= st_nxt;
    end
  end

  // read data, settings from the active word and their registered decoded views
  assign o_rdata                 = st_r.rdata;
  assign o_ref_divide_count      = st_r.active[pdx_pkg::REF_LSB +: pdx_pkg::REF_W];
  assign o_main_loop_shutdown    = st_r.active[pdx_pkg::SHUT_BIT];
  assign o_fb_a_count            = st_r.active[pdx_pkg::FB_LSB +: pdx_pkg::FB_A_W];
  assign o_fb_m_count            = st_r.active[pdx_pkg::FB_LSB + pdx_pkg::FB_A_W +:
                                               pdx_pkg::FB_W - pdx_pkg::FB_A_W];
  assign o_post_stage_a          = st_r.post_a;
  assign o_post_stage_b          = st_r.post_b;
  assign o_post_stage_c          = st_r.post_c;
  assign o_post_ratio_total      = st_r.post_total;
  assign o_xtal_pump_current     = st_r.active[pdx_pkg::PUMP_LSB +: 2];
  assign o_xtal_pump_tenth_ua    = st_r.pump_ua;
  assign o_xtal_divider_select   = st_r.active[pdx_pkg::XDIV_LSB +: 3];
  assign o_xtal_divide_ratio     = st_r.xdiv;
  assign o_xtal_osc_powerdown    = st_r.osc_pd;
  assign o_xtal_fine_tune_enable = st_r.active[pdx_pkg::FINE_BIT];
  assign o_xtal_tune_polarity    = st_r.active[pdx_pkg::POL_BIT];
  assign o_xtal_loop_powerdown   = st_r.active[pdx_pkg::XPD_BIT];
  assign o_crystal_load_trim     = st_r.active[pdx_pkg::TRIM_LSB +: 4];
  assign o_load_cap_centi_pf     = st_r.cap;

  logic post_ab_tick;
  logic post_bc_tick;

  // reference divider ahead of the phase detector
  pdx_tick_divider #(.W(pdx_pkg::REF_W)) u_ref_div (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_tick  (i_ref_tick),
    .i_ratio (o_ref_divide_count),
    .o_tick  (o_pd_ref_tick)
  );

  // three post stages in cascade
  pdx_tick_divider #(.W(4)) u_post_a (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_tick  (i_vco_tick),
    .i_ratio (st_r.post_a),
    .o_tick  (post_ab_tick)
  );

  pdx_tick_divider #(.W(4)) u_post_b (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_tick  (post_ab_tick),
    .i_ratio (st_r.post_b),
    .o_tick  (post_bc_tick)
  );

  pdx_tick_divider #(.W(4)) u_post_c (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_tick  (post_bc_tick),
    .i_ratio (st_r.post_c),
    .o_tick  (o_post_tick)
  );

endmodule

// ==== hw/pdx_pkg.sv ====
// package: control word layout, bus map, reset values and decode tables
package pdx_pkg;

  // register bus shape and map
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 8;
  localparam logic [3:0]  CTRL_LAST_ADR = 4'h7;  // control bytes sit at 0..7
  localparam logic [3:0]  STATUS_ADR    = 4'h8;
  localparam logic [63:0] CTRL_RESET    = 64'h0000_0000_0000_0000;
  localparam logic [7:0]  RDATA_RESET   = 8'h00;

  // field positions in the 64-bit control word
  localparam int REF_LSB   = 0;
  localparam int REF_W     = 12;
  localparam int SHUT_BIT  = 13;
  localparam int POSTA_LSB = 16;
  localparam int POSTB_LSB = 18;
  localparam int POSTC_LSB = 20;
  localparam int FB_LSB    = 24;
  localparam int FB_W      = 14;
  localparam int FB_A_W    = 3;
  localparam int XDIV_LSB  = 49;
  localparam int PUMP_LSB  = 52;
  localparam int POL_BIT   = 54;
  localparam int XPD_BIT   = 55;
  localparam int TRIM_LSB  = 56;
  localparam int FINE_BIT  = 61;

  // reserved bits always held at zero
  localparam logic [63:0] RSV_MASK = 64'h0000_0000_00c0_0000;

  // fields that straddle a byte boundary commit on their upper byte
  localparam logic [2:0]  REF_HI_BYTE  = 3'h1;
  localparam logic [2:0]  REF_LO_BYTE  = 3'h0;
  localparam logic [2:0]  FB_HI_BYTE   = 3'h4;
  localparam logic [2:0]  FB_LO_BYTE   = 3'h3;
  localparam logic [63:0] REF_LO_MASK  = 64'h0000_0000_0000_00ff;
  localparam logic [63:0] FB_LO_MASK   = 64'h0000_0000_ff00_0000;
  localparam logic [63:0] BYTE0_MASK   = 64'h0000_0000_0000_00ff;

  // status register bit positions
  localparam int ST_PEND_REF = 0;
  localparam int ST_PEND_FB  = 1;
  localparam int ST_OSC_PD   = 2;
  localparam int ST_XPD      = 3;
  localparam int ST_SHUT     = 4;

  localparam logic [2:0] XDIV_OFF_CODE = 3'h7;

  // post stage ratios
  localparam logic [3:0] POST_A_TAB [0:3] = '{4'h1, 4'h2, 4'h4, 4'h8};
  localparam logic [3:0] POST_BC_TAB[0:3] = '{4'h1, 4'h3, 4'h5, 4'h4};

  // crystal pump current in tenths of a microamp
  localparam logic [7:0] PUMP_TAB[0:3] = '{8'h0f, 8'h32, 8'h50, 8'hf0};

  // crystal loop divide ratio, last code is oscillator power-down
  localparam logic [11:0] XDIV_TAB[0:7] = '{12'h001, 12'hc00, 12'hc54, 12'h97e,
                                           12'h9c4, 12'hfa0, 12'hd2f, 12'h000};

  // load capacitance in hundredths of a picofarad
  localparam logic [11:0] CAP_TAB[0:15] = '{12'h3e8, 12'h43c, 12'h491, 12'h4e5,
                                           12'h53a, 12'h58e, 12'h5e2, 12'h637,
                                           12'h68b, 12'h6df, 12'h733, 12'h788,
                                           12'h7dd, 12'h831, 12'h885, 12'h8da};

endpackage

// ==== hw/pdx_tick_divider.sv ====
// tick divider: passes one enable pulse out of every ratio pulses in
`timescale 1ns/1ps
module pdx_tick_divider #(
  parameter int W = 12
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_ratio,
  output logic              o_tick
);

  typedef struct packed {
    logic [W-1:0] count;
    logic         tick;
  } pdx_div_state_type;

  pdx_div_state_type st_r;
  pdx_div_state_type st_nxt;

  // count input ticks, wrap at ratio; ratio 0 behaves as 1
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (i_tick) begin
      if ((i_ratio <= W'(1)) || (st_r.count >= i_ratio - W'(1))) begin
        st_nxt.count = '0;
        st_nxt.tick  = 1'b1;
      end else begin
        st_nxt.count = st_r.count + W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_tick = st_r.tick;

endmodule
